// ---- hdl/chan_pkg.sv ----
// shared constants, types and register map of the serial channel
package chan_pkg;
   localparam int unsigned REF_RATIO = 16; // reference clocks per bit
   localparam logic [3:0] REF_HALF = 4'h8; // mid-bit reference count
   localparam logic [3:0] NORM_ONES = 4'h8; // ones for normal priority
   localparam logic [3:0] LOW_ONES = 4'ha; // ones for lowered priority
   localparam logic [3:0] ONES_MAX = 4'hf;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned POOL_SIZE = 16;
   // register byte offsets
   localparam logic [5:0] CFG0_OFS = 6'h00;
   localparam logic [5:0] CFG2_OFS = 6'h04;
   localparam logic [5:0] CFG3_OFS = 6'h08;
   localparam logic [5:0] TXD_OFS = 6'h0c;
   localparam logic [5:0] CMD_OFS = 6'h10;
   localparam logic [5:0] STAT_OFS = 6'h14;
   localparam logic [5:0] ISR_OFS = 6'h18;
   localparam logic [5:0] MASK_OFS = 6'h1c;
   localparam logic [5:0] RXD_OFS = 6'h20;
   // command and interrupt bit positions
   localparam int unsigned CMD_SEND = 0;
   localparam int unsigned CMD_RESET = 1;
   localparam int unsigned IRQ_ALL_SENT = 0;
   localparam int unsigned IRQ_POOL_READY = 1;
   localparam int unsigned IRQ_MSG_REPEAT = 2;
   localparam int unsigned IRQ_SYNC = 3;
   localparam logic [11:0] BRG_DIV_RST = 12'h001;
   // channel configuration fields
   typedef struct packed {
      logic clk_src_brg; // transmit clock from reference/16
      logic biphase; // bi-phase line coding
      logic bisync; // 0 hdlc/sdlc, 1 bisync
      logic bus_timing_select_hi; // timing mode bit 1
      logic bus_timing_select_lo; // timing mode bit 0
   } cfg_s;
   // recovered clock events, rise and sample one system clock wide
   typedef struct packed {
      logic rise; // recovered clock rising
      logic sample; // mid-bit sample point
      logic rx_bit; // sampled data
      logic in_sync; // bi-phase lock state
   } dpll_s;
endpackage

// ---- hdl/sync2.sv ----
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module sync2 (
   input wire logic core_clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic d, // asynchronous level
   output logic q // synchronised level
);
   logic meta_r;
   // first stage feeds only the second
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= 1'b1;
         q <= 1'b1;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ---- hdl/dpll.sv ----
// clock recovery from 16x reference enable
`timescale 1ns/1ps
module dpll (
   input wire logic core_clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic ref_en, // reference clock enable
   input wire logic rx_in, // synchronised receive data
   input wire logic phase_shift_disable, // no half-bit shift
   input wire logic biphase, // bi-phase coding
   output chan_pkg::dpll_s dout // recovered events
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [4:0] gap_r;
   logic rx_d_r;
   logic edge_w;
   logic spike;
   logic ps_hit;
   logic late;
   logic early;
   // window fields from phase count
   always_comb begin
      edge_w = ref_en && (rx_in != rx_d_r);
      spike = gap_r < 5'(chan_pkg::REF_RATIO);
      ps_hit = 1'b0;
      late = 1'b0;
      early = 1'b0;
      if (biphase) begin
         late = cnt_r >= 4'h1 && cnt_r <= 4'h3;
         early = cnt_r >= 4'hc && cnt_r <= 4'he;
      end else if (phase_shift_disable) begin
         late = cnt_r >= 4'h1 && cnt_r <= 4'h7;
         early = cnt_r >= 4'h8 && cnt_r <= 4'he;
      end else begin
         late = cnt_r >= 4'h1 && cnt_r <= 4'h4;
         early = cnt_r >= 4'hb && cnt_r <= 4'he;
         ps_hit = edge_w && !spike && cnt_r >= 4'h6 && cnt_r <= 4'h9;
      end
      cnt_nxt = cnt_r + 4'h1;
      if (ps_hit) begin
         cnt_nxt = cnt_r + chan_pkg::REF_HALF;
      end else if (edge_w && !spike && late) begin
         cnt_nxt = cnt_r;
      end else if (edge_w && !spike && early) begin
         cnt_nxt = cnt_r + 4'h2;
      end
   end
   // phase counter stepped on reference enables
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 4'h0;
         gap_r <= 5'h00;
         rx_d_r <= 1'b1;
      end else if (ref_en) begin
         cnt_r <= cnt_nxt;
         rx_d_r <= rx_in;
         if (edge_w) begin
            gap_r <= 5'h00;
         end else if (gap_r != 5'h1f) begin
            gap_r <= gap_r + 5'h01;
         end
      end
   end
   // event outputs and sync state
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dout <= '0;
      end else begin
         dout.rise <= ref_en && cnt_nxt < cnt_r;
         dout.sample <= ref_en && (ps_hit || (cnt_r < 4'h8 && cnt_nxt >= 4'h8));
         if (ref_en && (ps_hit || (cnt_r < 4'h8 && cnt_nxt >= 4'h8))) begin
            dout.rx_bit <= rx_in;
         end
         if (!biphase) begin
            dout.in_sync <= 1'b0;
         end else if (edge_w && !spike) begin
            dout.in_sync <= !(late || early);
         end
      end
   end
endmodule

// ---- hdl/bus_channel.sv ----
// serial channel: clock recovery, bus access and collision handling
// Function
// - recovery runs from a reference enable at sixteen times the bit rate.
// - transmit clock is reference divided by sixteen or the recovered clock.
// - edges sixteen or fewer reference clocks apart make no correction.
// - an edge in an adjust field moves phase one sixteenth bit.
// - in NRZ an edge in the shift field forces resample, half-bit shift.
// - edges outside adjust and shift fields leave the phase alone.
// - phase shift disable drops the shift and widens adjust fields.
// - bi-phase lock state shows as status flag and maskable interrupt.
// - bus idle after eight ones, busy from the first zero.
// - output idles at one when bus taken or nothing to send.
// - each sent bit is checked against feedback; mismatch stops sending.
// - hdlc collision retries if frame start held, else repeat interrupt.
// - bisync collision resets transmitter and buffer, raises repeat interrupt.
// - normal priority starts only after eight ones on feedback.
// - after a good hdlc frame need ten ones, then back to eight.
// - timing 01 drives on rising edge, checks on the following falling.
// - timing 11 drives on falling edge, checks one period later.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module bus_channel (
   input wire logic core_clk, // 200 MHz clock
   input wire logic reset_n, // async reset, active low
   input wire logic [5:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic rxd_in, // serial receive pin
   input wire logic collision_feedback_in, // shared bus level
   output logic txd_out, // serial transmit level
   output logic txd_oe, // drive enable, high while pulling low
   output logic txclk_out, // transmit clock
   output logic irq // level interrupt
);
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} tx_e;
   ////////////////////////////////////////////////////////////////
   logic rx_s;
   logic cxd_s;
   chan_pkg::cfg_s cfg_r;
   logic [11:0] brg_div_r;
   logic phase_shift_disable;
   logic cfg3_psd_r;
   logic [3:0] isr_r;
   logic [3:0] mask_r;
   logic [3:0] isr_set;
   logic ack_r;
   logic wr_en;
   logic [7:0] tx_mem [chan_pkg::FIFO_DEPTH];
   logic [5:0] wr_cnt_r;
   logic [4:0] rd_ptr_r;
   logic [2:0] bit_idx_r;
   logic start_held_r;
   tx_e tx_state_r;
   logic txd_r;
   logic sent_valid_r;
   logic prio_low_r;
   logic [3:0] ones_r;
   logic [11:0] brg_cnt_r;
   logic ref_en;
   logic [3:0] tx_div_r;
   logic tx_rise;
   logic tx_fall;
   logic chg_edge;
   logic chk_edge;
   logic bus_mode;
   logic collide;
   logic last_bit;
   logic start_ok;
   logic send_cmd;
   logic reset_cmd;
   logic sync_d_r;
   logic [7:0] rx_byte_r;
   chan_pkg::dpll_s dpll_o;

   // match of an address against a register offset
   function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
      return a == ofs;
   endfunction

   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   sync2 u_rx_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .d(rxd_in),
      .q(rx_s)
   );
   sync2 u_cxd_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .d(collision_feedback_in),
      .q(cxd_s)
   );

   ////////////////////////////////////////////////////////////////
   // reference enable from the baud divider
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         brg_cnt_r <= 12'h000;
      end else if (brg_cnt_r >= brg_div_r) begin
         brg_cnt_r <= 12'h000;
      end else begin
         brg_cnt_r <= brg_cnt_r + 12'h001;
      end
   end
   assign ref_en = brg_cnt_r >= brg_div_r;

   dpll u_dpll (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .ref_en(ref_en),
      .rx_in(rx_s),
      .phase_shift_disable(phase_shift_disable),
      .biphase(cfg_r.biphase),
      .dout(dpll_o)
   );

   // transmit clock divided by sixteen from the reference
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_div_r <= 4'h0;
      end else if (ref_en) begin
         tx_div_r <= tx_div_r + 4'h1;
      end
   end

   // transmit clock edges from the selected source
   always_comb begin
      if (cfg_r.clk_src_brg) begin
         tx_rise = ref_en && tx_div_r == 4'h0;
         tx_fall = ref_en && tx_div_r == chan_pkg::REF_HALF;
      end else begin
         tx_rise = dpll_o.rise;
         tx_fall = dpll_o.sample;
      end
   end

   // transmit clock level
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         txclk_out <= 1'b0;
      end else if (tx_rise) begin
         txclk_out <= 1'b1;
      end else if (tx_fall) begin
         txclk_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // timing mode selects the driving edge, checking stays on the falling edge
   assign bus_mode = cfg_r.bus_timing_select_lo;
   always_comb begin
      if (cfg_r.bus_timing_select_hi) begin
         chg_edge = tx_fall;
      end else begin
         chg_edge = tx_rise;
      end
      chk_edge = tx_fall;
   end

   // compare the driven bit with the bus level
   assign collide = bus_mode && tx_state_r == TX_SEND && chk_edge && sent_valid_r
      && txd_r != cxd_s;

   // consecutive ones seen on the feedback
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ones_r <= 4'h0;
      end else if (chk_edge) begin
         if (!cxd_s) begin
            ones_r <= 4'h0;
         end else if (ones_r != chan_pkg::ONES_MAX) begin
            ones_r <= ones_r + 4'h1;
         end
      end
   end

   // start gate from idle threshold and priority
   always_comb begin
      if (!bus_mode) begin
         start_ok = 1'b1;
      end else if (prio_low_r && !cfg_r.bisync) begin
         start_ok = ones_r >= chan_pkg::LOW_ONES;
      end else begin
         start_ok = ones_r >= chan_pkg::NORM_ONES;
      end
   end

   // priority class rotation
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prio_low_r <= 1'b0;
      end else if (tx_state_r == TX_SEND && chg_edge && last_bit && !cfg_r.bisync
            && bus_mode && !collide) begin
         prio_low_r <= 1'b1;
      end else if (ones_r >= chan_pkg::LOW_ONES) begin
         prio_low_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // register bus handshake, one wait state per access
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign wr_en = avs_write && ack_r;
   assign send_cmd = wr_en && hit(avs_address, chan_pkg::CMD_OFS)
      && avs_writedata[chan_pkg::CMD_SEND];
   assign reset_cmd = wr_en && hit(avs_address, chan_pkg::CMD_OFS)
      && avs_writedata[chan_pkg::CMD_RESET];
   assign phase_shift_disable = 1'b0 | cfg3_psd_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
      end
   end

   // configuration registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= '0;
         brg_div_r <= chan_pkg::BRG_DIV_RST;
         cfg3_psd_r <= 1'b0;
         mask_r <= 4'h0;
      end else if (wr_en) begin
         if (hit(avs_address, chan_pkg::CFG0_OFS)) begin
            cfg_r <= avs_writedata[4:0];
         end else if (hit(avs_address, chan_pkg::CFG2_OFS)) begin
            brg_div_r <= avs_writedata[11:0];
         end else if (hit(avs_address, chan_pkg::CFG3_OFS)) begin
            cfg3_psd_r <= avs_writedata[0];
         end else if (hit(avs_address, chan_pkg::MASK_OFS)) begin
            mask_r <= avs_writedata[3:0];
         end
      end
   end

   // read data captured in the wait cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_r) begin
         if (hit(avs_address, chan_pkg::CFG0_OFS)) begin
            avs_readdata <= {27'h0, cfg_r};
         end else if (hit(avs_address, chan_pkg::CFG2_OFS)) begin
            avs_readdata <= {20'h0, brg_div_r};
         end else if (hit(avs_address, chan_pkg::CFG3_OFS)) begin
            avs_readdata <= {31'h0, cfg3_psd_r};
         end else if (hit(avs_address, chan_pkg::TXD_OFS)) begin
            avs_readdata <= {26'h0, wr_cnt_r};
         end else if (hit(avs_address, chan_pkg::STAT_OFS)) begin
            avs_readdata <= {26'h0, tx_state_r, dpll_o.in_sync, prio_low_r,
               ones_r >= chan_pkg::NORM_ONES, start_held_r};
         end else if (hit(avs_address, chan_pkg::ISR_OFS)) begin
            avs_readdata <= {28'h0, isr_r};
         end else if (hit(avs_address, chan_pkg::MASK_OFS)) begin
            avs_readdata <= {28'h0, mask_r};
         end else if (hit(avs_address, chan_pkg::RXD_OFS)) begin
            avs_readdata <= {24'h0, rx_byte_r};
         end else begin
            avs_readdata <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // frame buffer written by software
   always_ff @(posedge core_clk) begin
      if (wr_en && hit(avs_address, chan_pkg::TXD_OFS)
            && wr_cnt_r < 6'(chan_pkg::FIFO_DEPTH)) begin
         tx_mem[wr_cnt_r[4:0]] <= avs_writedata[7:0];
      end
   end

   assign last_bit = bit_idx_r == 3'h7 && 6'(rd_ptr_r) + 6'h01 >= wr_cnt_r;

   // transmitter sequencing and collision outcome
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_state_r <= TX_IDLE;
         wr_cnt_r <= 6'h00;
         rd_ptr_r <= 5'h00;
         bit_idx_r <= 3'h0;
         txd_r <= 1'b1;
         sent_valid_r <= 1'b0;
         start_held_r <= 1'b1;
      end else if (reset_cmd) begin
         tx_state_r <= TX_IDLE;
         wr_cnt_r <= 6'h00;
         rd_ptr_r <= 5'h00;
         bit_idx_r <= 3'h0;
         txd_r <= 1'b1;
         sent_valid_r <= 1'b0;
         start_held_r <= 1'b1;
      end else if (collide) begin
         txd_r <= 1'b1;
         sent_valid_r <= 1'b0;
         rd_ptr_r <= 5'h00;
         bit_idx_r <= 3'h0;
         if (!cfg_r.bisync && start_held_r) begin
            tx_state_r <= TX_WAIT;
         end else begin
            tx_state_r <= TX_IDLE;
            wr_cnt_r <= 6'h00;
            start_held_r <= 1'b1;
         end
      end else begin
         case (tx_state_r)
            TX_IDLE: begin
               txd_r <= 1'b1;
               if (send_cmd && wr_cnt_r != 6'h00) begin
                  tx_state_r <= TX_WAIT;
               end else if (wr_en && hit(avs_address, chan_pkg::TXD_OFS)
                     && wr_cnt_r < 6'(chan_pkg::FIFO_DEPTH)) begin
                  wr_cnt_r <= wr_cnt_r + 6'h01;
               end
            end
            TX_WAIT: begin
               txd_r <= 1'b1;
               if (chg_edge && start_ok) begin
                  tx_state_r <= TX_SEND;
                  txd_r <= tx_mem[rd_ptr_r][bit_idx_r];
                  sent_valid_r <= 1'b1;
               end
            end
            default: begin
               if (chg_edge) begin
                  if (last_bit) begin
                     tx_state_r <= TX_IDLE;
                     txd_r <= 1'b1;
                     sent_valid_r <= 1'b0;
                     wr_cnt_r <= 6'h00;
                     rd_ptr_r <= 5'h00;
                     bit_idx_r <= 3'h0;
                     start_held_r <= 1'b1;
                  end else begin
                     if (bit_idx_r == 3'h7) begin
                        rd_ptr_r <= rd_ptr_r + 5'h01;
                        if (rd_ptr_r == 5'(chan_pkg::POOL_SIZE - 1)) begin
                           start_held_r <= 1'b0;
                        end
                     end
                     txd_r <= tx_mem[bit_idx_r == 3'h7 ? rd_ptr_r + 5'h01 :
                        rd_ptr_r][3'(bit_idx_r + 3'h1)];
                     bit_idx_r <= bit_idx_r + 3'h1;
                  end
               end
            end
         endcase
      end
   end

   // open-drain style output, enable while pulling low
   assign txd_out = txd_r;
   assign txd_oe = !txd_r;

   ////////////////////////////////////////////////////////////////
   // received bits shifted into a byte
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_byte_r <= 8'h00;
         sync_d_r <= 1'b0;
      end else begin
         sync_d_r <= dpll_o.in_sync;
         if (dpll_o.sample) begin
            rx_byte_r <= {dpll_o.rx_bit, rx_byte_r[7:1]};
         end
      end
   end

   // interrupt events
   always_comb begin
      isr_set = 4'h0;
      isr_set[chan_pkg::IRQ_ALL_SENT] = tx_state_r == TX_SEND && chg_edge && last_bit
         && !collide;
      isr_set[chan_pkg::IRQ_POOL_READY] = tx_state_r == TX_SEND && chg_edge && !collide
         && bit_idx_r == 3'h7 && rd_ptr_r == 5'(chan_pkg::POOL_SIZE - 1);
      isr_set[chan_pkg::IRQ_MSG_REPEAT] = collide && (cfg_r.bisync || !start_held_r);
      isr_set[chan_pkg::IRQ_SYNC] = cfg_r.biphase && sync_d_r != dpll_o.in_sync;
   end

   // sticky status, set wins over write-one clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         isr_r <= 4'h0;
      end else if (wr_en && hit(avs_address, chan_pkg::ISR_OFS)) begin
         isr_r <= (isr_r & ~avs_writedata[3:0]) | isr_set;
      end else begin
         isr_r <= isr_r | isr_set;
      end
   end

   assign irq = |(isr_r & mask_r);
endmodule

// ---- sim/bus_channel_assertions.sv ----
// port checker of the bus channel
`timescale 1ns/1ps
module bus_channel_assertions (
   input wire logic core_clk, // clk
   input wire logic reset_n, // reset
   input wire logic [5:0] avs_address, // addr
   input wire logic avs_write, // write
   input wire logic [31:0] avs_writedata, // data
   input wire logic avs_waitrequest, // stall
   input wire logic collision_feedback_in, // bus
   input wire logic txd_out, // tx
   input wire logic txd_oe, // tx enable
   input wire logic txclk_out, // tx clock
   input wire logic irq // irq
);
   logic [4:0] cfg_r;
   logic [3:0] mask_r;
   logic sent_r;
   logic [3:0] ones_r;
   logic [8:0] hi_r;
   logic [5:0] gap_r;
   logic wr_ok;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   /////////////////////////////////////////
   // shadows of host writes, bus counters
   assign wr_ok = avs_write && !avs_waitrequest;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= 5'h00;
         mask_r <= 4'h0;
         sent_r <= 1'b0;
         ones_r <= 4'h0;
         hi_r <= 9'h000;
         gap_r <= 6'h3f;
      end else begin
         if (wr_ok && avs_address == 6'h00) cfg_r <= avs_writedata[4:0];
         if (wr_ok && avs_address == 6'h1c) mask_r <= avs_writedata[3:0];
         if (wr_ok && avs_address == 6'h10 && avs_writedata[0]) sent_r <= 1'b1;
         if ($fell(txclk_out))
            ones_r <= !$past(collision_feedback_in, 3) ? 4'h0 : ones_r + {3'h0, ones_r != 4'hf};
         hi_r <= !txd_out ? 9'h000 : hi_r + {8'h00, hi_r != 9'h1ff};
         if (wr_ok && avs_address == 6'h00) gap_r <= 6'h3f;
         else if ($rose(txclk_out)) gap_r <= 6'h00;
         else gap_r <= gap_r + {5'h00, gap_r != 6'h3f};
      end
   end
   /////////////////////////////////////////
   // properties
   property p_oe; txd_oe == !txd_out; endproperty
   a_oe: assert property (p_oe)
      else $error("enable does not match tx level");
   property p_quiet; !sent_r |-> txd_out; endproperty
   a_quiet: assert property (p_quiet)
      else $error("tx low with nothing to send");
   property p_rise; $fell(txd_out) && cfg_r[1:0] == 2'b01 |-> txclk_out; endproperty
   a_rise: assert property (p_rise)
      else $error("bit not launched on rising tx clock");
   property p_fall; $fell(txd_out) && cfg_r[1:0] == 2'b11 |-> !txclk_out; endproperty
   a_fall: assert property (p_fall)
      else $error("bit not launched on falling tx clock");
   sequence s_clash; cfg_r[0] && (txd_out && !collision_feedback_in) [*4] ##1 $fell(txclk_out);
   endsequence
   property p_abort; s_clash |-> ##2 txd_out [*8]; endproperty
   a_abort: assert property (p_abort)
      else $error("sending went on after collision");
   property p_start; $fell(txd_out) && cfg_r[0] && hi_r >= 9'd300 |-> ones_r >= 4'd7;
   endproperty
   a_start: assert property (p_start)
      else $error("frame started without idle bus");
   property p_div; $rose(txclk_out) && cfg_r[4] && gap_r < 6'd40 |-> gap_r == 6'd31;
   endproperty
   a_div: assert property (p_div)
      else $error("tx clock period not sixteen references");
   property p_mask; mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !irq; endproperty
   a_mask: assert property (p_mask)
      else $error("irq with all sources masked");
   c_start: cover property ($fell(txd_out) && cfg_r[1:0] == 2'b11);
   c_clash: cover property (s_clash);
   c_irq: cover property ($rose(irq));
endmodule

// ---- sim/bus_station.sv ----
// second station on the shared open-drain bus
`timescale 1ns/1ps
module bus_station (
   input wire logic core_clk, // clk
   input wire logic reset_n, // reset
   input wire logic bus_lvl, // bus level
   input wire logic go, // request frame
   input wire logic [7:0] frame_byte, // byte
   output logic st_oe, // pulls low
   output logic st_busy // pending
);
   logic [4:0] ph_r;
   logic [3:0] ones_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   /////////////////////////////////////////
   // 32-cycle bits, idle count, send, back off
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ph_r <= 5'h00;
         ones_r <= 4'h0;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         st_oe <= 1'b0;
         st_busy <= 1'b0;
      end else begin
         ph_r <= ph_r + 5'h01;
         if (go) begin
            st_busy <= 1'b1;
            sh_r <= frame_byte;
         end
         if (ph_r == 5'h10) begin
            ones_r <= bus_lvl ? ones_r + {3'h0, ones_r != 4'hf} : 4'h0;
            if (bit_r != 4'h0 && !st_oe && !bus_lvl) bit_r <= 4'h0;
         end
         if (ph_r == 5'h1f && st_busy) begin
            if (bit_r == 4'h8) begin
               st_oe <= 1'b0;
               bit_r <= 4'h0;
               st_busy <= 1'b0;
            end else if (bit_r != 4'h0 || ones_r >= 4'h8) begin
               st_oe <= !sh_r[bit_r[2:0]];
               bit_r <= bit_r + 4'h1;
            end
         end
      end
   end
endmodule

// ---- sim/tb_dpll_and_bus_collision_access.sv ----
// bench: host bus, wire checks, collisions
`timescale 1ns/1ps
module tb_dpll_and_bus_collision_access;
   logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic txd_out, txd_oe, txclk_out, irq, st_oe, st_busy, go, bus;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, seed, q;
   logic [15:0] w;
   logic [7:0] d;
   int num_errors = 0;
   int checked = 0;
   int cyc = 0;
   assign bus = !(txd_oe || st_oe); // pull-up unless pulled low
   bus_channel DUT (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .rxd_in(bus), .collision_feedback_in(bus), .txd_out,
      .txd_oe, .txclk_out, .irq);
   bus_station peer (.core_clk, .reset_n, .bus_lvl(bus), .go, .frame_byte(8'h00), .st_oe,
      .st_busy);
   always #2.5 core_clk = !core_clk;
   /////////////////////////////////////////
   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         close_out();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [31:0] lsb_first(input logic [15:0] v, input int i);
      return {31'h0, v[i]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus_op(input logic wr, input logic [5:0] a, input logic [31:0] v,
                         output logic [31:0] r);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      logic [31:0] r;
      bus_op(1'b1, a, v, r);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      bus_op(1'b0, a, 32'h0, r);
      chk(r & m, e);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   /////////////////////////////////////////
   // main sequence
   initial begin
      {core_clk, reset_n, avs_read, avs_write, go} = 5'h00;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      seed = 32'd79;
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(6'h18, 32'hf, 32'h0);
      rd(6'h3c, 32'hffffffff, 32'h0);
      chk({31'h0, txd_out}, 32'h1);
      wr(6'h08, 32'h1);
      rd(6'h08, 32'h1, 32'h1);
      $display("test reset done");
      seed = xs(seed);
      w = seed[15:0] & 16'hfffe;
      wr(6'h1c, 32'h1);
      wr(6'h00, 32'h11);
      wr(6'h0c, {24'h0, w[7:0]});
      wr(6'h0c, {24'h0, w[15:8]});
      wr(6'h10, 32'h1);
      while (txd_out !== 1'b0) @(posedge core_clk);
      for (int i = 0; i < 16; i++) begin
         @(negedge txclk_out);
         #1;
         chk({31'h0, txd_out}, lsb_first(w, i));
      end
      while (irq !== 1'b1) @(posedge core_clk);
      rd(6'h14, 32'h4, 32'h4);
      wr(6'h1c, 32'h0);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      wr(6'h18, 32'h1);
      rd(6'h18, 32'h1, 32'h0);
      repeat (12 * 32) @(posedge core_clk);
      rd(6'h14, 32'h4, 32'h0);
      $display("test clean frame done");
      wr(6'h1c, 32'h5);
      for (int m = 0; m < 2; m++) begin
         seed = xs(seed);
         d = (seed[7:0] | 8'h0f) & 8'h7f;
         wr(6'h00, m ? 32'h17 : 32'h13);
         wr(6'h0c, {24'h0, d});
         wr(6'h10, 32'h1);
         q = 32'h0;
         while (q[5:4] !== 2'h2) bus_op(1'b0, 6'h14, 32'h0, q);
         go <= 1'b1;
         @(posedge core_clk);
         go <= 1'b0;
         while (irq !== 1'b1) @(posedge core_clk);
         rd(6'h18, 32'h5, m ? 32'h4 : 32'h1);
         if (m) rd(6'h0c, 32'hff, 32'h0);
         wr(6'h18, 32'h5);
         while (st_busy !== 1'b0) @(posedge core_clk);
         repeat (12 * 32) @(posedge core_clk);
         $display("test collision mode %0d done", m);
      end
      close_out();
   end
endmodule
bind bus_channel bus_channel_assertions u_chk (.core_clk, .reset_n, .avs_address, .avs_write,
   .avs_writedata, .avs_waitrequest, .collision_feedback_in, .txd_out, .txd_oe, .txclk_out, .irq);
